/* tdr_checker.sv */
`timescale 1ns/1ps
module tdr_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [tdr_pkg::ADDR_W-1:0] addr,
  input wire logic [tdr_pkg::DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [tdr_pkg::DATA_W-1:0] rdata
);
  import tdr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // --------
  // Last word 0 read, owned or not, kept to judge the release write
  // --------
  logic [DATA_W-1:0] w0_seen;
  logic [ADDR_W-1:0] w0_addr;
  wire rd_any = req && ack && !we;
  wire rd_w0 = rd_any && addr[2:0] == 3'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      w0_seen <= WORD_RST;
      w0_addr <= ADDR_RST;
    end else if (rd_w0) begin
      w0_seen <= rdata;
      w0_addr <= addr;
    end
  end
  // --------
  // Memory link
  // --------
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(we); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved early");
  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_align; req |-> !addr[0]; endproperty
  a_align: assert property (p_align) else $error("odd word address");
  property p_next_word;
    rd_any && addr[2:0] != 3'h6 && (addr[2:0] != 3'h0 || rdata[OWN_BIT])
      |=> req && !we && addr == $past(addr) + W1_OFS;
  endproperty
  a_next_word: assert property (p_next_word) else $error("entry not read in order");
  property p_stall; rd_w0 && !rdata[OWN_BIT] |=> !req || addr == $past(addr); endproperty
  a_stall: assert property (p_stall) else $error("unowned entry passed");
  property p_hold_w3; rd_any && addr[2:0] == 3'h6 |=> !req; endproperty
  a_hold_w3: assert property (p_hold_w3) else $error("release before send");
  property p_release; req && we |-> addr == w0_addr && wdata == {1'b0, w0_seen[14:0]}; endproperty
  a_release: assert property (p_release) else $error("bad release write");
  c_release: cover property (req && we && ack);
  c_stall: cover property (rd_w0 && !rdata[OWN_BIT]);
  c_owned: cover property (rd_w0 && rdata[OWN_BIT]);
endmodule

/* tdr_device.sv */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - Word 0 bit 15 set means device owns
// - Host fills buffer before handing it over
// - Device releases only after acknowledged transmit
// - Released entry is never touched by giver
// - Bit 14 host/processor select is ignored
// - Host marks first buffer, set if unchained
// - Host marks last buffer, set if unchained
// - First and last set means single buffer
// - Host writes reserved bits as zero
// - Japan mode copies bits 11:10 to priority
// - Upper address byte in word 0, untouched
// - Word 1 low address, bit 0 zero
// - Word 2 is information plus service octets
// - Length used on first buffer, selector zero
// - Unit length is an unsigned positive count
// - Entry is four consecutive words in ring
// - Word 3 buffer octets, two's complement
module tdr_device (
  input wire logic ref_clk,
  input wire logic rst_n,
  tdr_mem_if.dev bus,
  input wire logic run,
  input wire logic [tdr_pkg::ADDR_W-1:0] ring_base,
  input wire logic [tdr_pkg::IDX_W-1:0] ring_len,
  input wire logic japan_mode_enable,
  input wire logic length_source_select,
  input wire logic tx_done,
  output logic buf_valid,
  output logic [tdr_pkg::ADDR_W-1:0] tx_buffer_address,
  output logic [tdr_pkg::DATA_W-1:0] buffer_octet_count,
  output logic first_buffer_flag,
  output logic last_buffer_flag,
  output logic single_buffer,
  output logic [tdr_pkg::DATA_W-1:0] unit_length,
  output logic unit_length_valid,
  output logic [tdr_pkg::PRIO_W-1:0] priority_indication,
  output logic desc_released,
  output logic [tdr_pkg::IDX_W-1:0] ring_index
);
  import tdr_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  tdr_state_t state;
  logic req;
  logic we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] w0;
  logic [DATA_W-1:0] w1;
  logic [DATA_W-1:0] w2;

  assign bus.req = req;
  assign bus.we = we;
  assign bus.addr = addr;
  assign bus.wdata = wdata;

  // ----------------------------------------
  // Address and field decode
  // ----------------------------------------
  // Four words per entry, entries packed back to back
  wire [ADDR_W-1:0] entry_ofs = {13'h0000, ring_index, 3'b000};
  wire [ADDR_W-1:0] desc_base = ring_base + entry_ofs;
  wire [IDX_W-1:0] last_idx = ring_len - 8'h01;
  wire [IDX_W-1:0] next_idx = (ring_index == last_idx) ? IDX_RST
                              : ring_index + 8'h01;
  wire got = req & bus.ack;
  // Only bit 15 decides ownership; bit 14 is never looked at
  wire owned = bus.rdata[OWN_BIT];
  // Buffer address: high byte from word 0, low word from word 1
  wire [ADDR_W-1:0] buf_addr = {w0[ADDR_HI_MSB:0], w1[DATA_W-1:1], 1'b0};
  // Word 3 holds minus the count; negate for a plain octet count
  wire [DATA_W-1:0] octets = WORD_RST - bus.rdata;
  wire is_first = w0[FIRST_BIT];
  wire is_last = w0[LAST_BIT];
  // Reserved bits 9:8 are not decoded, so stray ones do no harm
  wire [PRIO_W-1:0] prio = japan_mode_enable ? w0[PRIO_HI:PRIO_LO]
                           : 2'b00;
  // Word 2 matters only on the first buffer with the selector low
  wire len_used = is_first & ~length_source_select;
  // Release keeps every field but the flag
  wire [DATA_W-1:0] release_word = {1'b0, w0[OWN_BIT-1:0]};

  // ----------------------------------------
  // Descriptor walk
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      req <= 1'b0;
      we <= 1'b0;
      addr <= ADDR_RST;
      wdata <= WORD_RST;
      w0 <= WORD_RST;
      w1 <= WORD_RST;
      w2 <= WORD_RST;
      ring_index <= IDX_RST;
      desc_released <= 1'b0;
    end else begin
      desc_released <= 1'b0;
      case (state)
        S_IDLE: begin
          if (run) begin
            req <= 1'b1;
            we <= 1'b0;
            addr <= desc_base + W0_OFS;
            state <= S_RD0;
          end
        end
        S_RD0: begin
          if (got) begin
            w0 <= bus.rdata;
            // Host still owns it: poll the same entry again while run stays high, else go idle
            if (owned) begin
              addr <= desc_base + W1_OFS;
              state <= S_RD1;
            end else if (!run) begin
              req <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        S_RD1: begin
          if (got) begin
            w1 <= bus.rdata;
            addr <= desc_base + W2_OFS;
            state <= S_RD2;
          end
        end
        S_RD2: begin
          if (got) begin
            w2 <= bus.rdata;
            addr <= desc_base + W3_OFS;
            state <= S_RD3;
          end
        end
        S_RD3: begin
          if (got) begin
            req <= 1'b0;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          // Flag stays set until the far end has acknowledged
          if (tx_done) begin
            req <= 1'b1;
            we <= 1'b1;
            addr <= desc_base + W0_OFS;
            wdata <= release_word;
            state <= S_REL;
          end
        end
        S_REL: begin
          // After this write the entry is the host's; no more writes
          if (got) begin
            we <= 1'b0;
            desc_released <= 1'b1;
            ring_index <= next_idx;
            if (run) begin
              addr <= ring_base + {13'h0000, next_idx, 3'b000};
              state <= S_RD0;
            end else begin
              req <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          req <= 1'b0;
          we <= 1'b0;
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Buffer hand-off to the transmitter
  // ----------------------------------------
  // Fields are latched once word 3 arrives and hold for the whole send
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_valid <= 1'b0;
      tx_buffer_address <= ADDR_RST;
      buffer_octet_count <= WORD_RST;
      first_buffer_flag <= 1'b0;
      last_buffer_flag <= 1'b0;
      single_buffer <= 1'b0;
      unit_length <= WORD_RST;
      unit_length_valid <= 1'b0;
      priority_indication <= 2'b00;
    end else begin
      if (state == S_RD3 && got) begin
        buf_valid <= 1'b1;
        tx_buffer_address <= buf_addr;
        buffer_octet_count <= octets;
        first_buffer_flag <= is_first;
        last_buffer_flag <= is_last;
        // Both flags: the unit is whole in this buffer
        single_buffer <= is_first & is_last;
        // Unsigned information plus service octet count
        unit_length <= len_used ? w2 : WORD_RST;
        unit_length_valid <= len_used;
        priority_indication <= prio;
      end else if (state == S_SEND && tx_done) begin
        buf_valid <= 1'b0;
        // Length reads zero whenever it is not valid, so no stale unit leaks out
        unit_length <= WORD_RST;
        unit_length_valid <= 1'b0;
      end
    end
  end
endmodule

/* tdr_host_mem.sv */
`timescale 1ns/1ps
module tdr_host_mem (
  input wire logic ref_clk,
  input wire logic rst_n,
  tdr_mem_if.mem bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tdr_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import tdr_pkg::*;

  // ----------------------------------------
  // Shared memory
  // ----------------------------------------
  // Software fills buffers and sets the device flag last, through
  // the same window, so a buffer is whole before its hand-over
  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [ADDR_W-1:0] win;
  logic [31:0] rel_cnt;
  logic ack;
  logic [DATA_W-1:0] rdata;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire apb_acc = psel & penable & ~pready;
  wire hit_win = (paddr == REG_WIN);
  wire hit_data = (paddr == REG_DATA);
  wire hit_rel = (paddr == REG_REL);
  wire mapped = hit_win | hit_data | hit_rel;
  wire apb_mem_wr = apb_acc & pwrite & hit_data;
  wire [MEM_AW-1:0] win_idx = win[MEM_AW:1];
  wire [MEM_AW-1:0] dev_idx = bus.addr[MEM_AW:1];
  // Software write wins the array; the device simply waits a cycle
  wire dev_go = bus.req & ~ack & ~apb_mem_wr;
  // A device write to word 0 with the flag clear is a release
  wire dev_rel = dev_go & bus.we & (bus.addr[2:0] == W0_OFS[2:0])
                 & ~bus.wdata[OWN_BIT];

  assign bus.ack = ack;
  assign bus.rdata = rdata;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= PRDATA_RST;
      win <= ADDR_RST;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~mapped;
      if (apb_acc & ~pwrite) begin
        prdata <= PRDATA_RST;
        if (hit_win)
          prdata <= {8'h00, win};
        if (hit_data)
          prdata <= {16'h0000, mem[win_idx]};
        if (hit_rel)
          prdata <= rel_cnt;
      end
      if (apb_acc & pwrite & hit_win)
        win <= pwdata[ADDR_W-1:0];
      if (apb_acc & hit_data)
        win <= win + WIN_STEP;
    end
  end

  // ----------------------------------------
  // Memory array and device port
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (apb_mem_wr)
      mem[win_idx] <= pwdata[DATA_W-1:0];
    else if (dev_go & bus.we)
      mem[dev_idx] <= bus.wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdata <= WORD_RST;
      rel_cnt <= PRDATA_RST;
    end else begin
      ack <= dev_go;
      if (dev_go & ~bus.we)
        rdata <= mem[dev_idx];
      if (dev_rel)
        rel_cnt <= rel_cnt + 32'h00000001;
    end
  end
endmodule

/* tdr_mem_if.sv */
`timescale 1ns/1ps
interface tdr_mem_if;
  import tdr_pkg::*;
  logic req;
  logic we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  modport dev (
    output req,
    output we,
    output addr,
    output wdata,
    input ack,
    input rdata
  );
  modport mem (
    input req,
    input we,
    input addr,
    input wdata,
    output ack,
    output rdata
  );
endinterface

/* tdr_pkg.sv */
package tdr_pkg;
  // ----------------------------------------
  // Descriptor layout
  // ----------------------------------------
  localparam int DESC_WORDS = 4;
  localparam int OWN_BIT = 15;
  localparam int HOSTSEL_BIT = 14;
  localparam int FIRST_BIT = 13;
  localparam int LAST_BIT = 12;
  localparam int PRIO_HI = 11;
  localparam int PRIO_LO = 10;
  localparam int ADDR_HI_MSB = 7;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int IDX_W = 8;
  localparam int PRIO_W = 2;
  // Byte offsets of the four words inside one entry
  localparam logic [ADDR_W-1:0] W0_OFS = 24'h000000;
  localparam logic [ADDR_W-1:0] W1_OFS = 24'h000002;
  localparam logic [ADDR_W-1:0] W2_OFS = 24'h000004;
  localparam logic [ADDR_W-1:0] W3_OFS = 24'h000006;
  localparam int ENTRY_SHIFT = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [IDX_W-1:0] IDX_RST = 8'h00;
  localparam logic [31:0] PRDATA_RST = 32'h00000000;
  // ----------------------------------------
  // Shared memory and APB map of the memory end
  // ----------------------------------------
  localparam int MEM_AW = 12;
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] REG_WIN = 8'h00;
  localparam logic [PADDR_W-1:0] REG_DATA = 8'h04;
  localparam logic [PADDR_W-1:0] REG_REL = 8'h08;
  localparam logic [ADDR_W-1:0] WIN_STEP = 24'h000002;
  // ----------------------------------------
  // Device states
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_RD0, S_RD1, S_RD2, S_RD3, S_SEND, S_REL
  } tdr_state_t;
endpackage

/* tx_descriptor_ring_handler_tb.sv */
`timescale 1ns/1ps
module tx_descriptor_ring_handler_tb;
  import tdr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, buf_valid, bv_q;
  logic run = 1'b0;
  logic japan_mode_enable = 1'b0;
  logic length_source_select = 1'b0;
  logic tx_done = 1'b0;
  logic first_buffer_flag, last_buffer_flag, single_buffer, unit_length_valid;
  logic desc_released, fst, lst;
  logic [23:0] tx_buffer_address;
  logic [15:0] buffer_octet_count, unit_length, cnt, w[4], w0s[4];
  logic [1:0] priority_indication;
  logic [7:0] ring_index;
  logic [61:0] expq[$];
  logic [63:0] seen_f;
  int miscompares = 0, samples_checked = 0, seed = 24, cyc = 0, rels = 0, i, k;
  tdr_mem_if mif();
  tdr_host_mem i_tdr_host_mem(.ref_clk, .rst_n, .bus(mif.mem), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  tdr_device i_tdr_device(.ref_clk, .rst_n, .bus(mif.dev), .run, .ring_base(24'h000100),
    .ring_len(8'h04), .japan_mode_enable, .length_source_select, .tx_done, .buf_valid,
    .tx_buffer_address, .buffer_octet_count, .first_buffer_flag, .last_buffer_flag,
    .single_buffer, .unit_length, .unit_length_valid, .priority_indication, .desc_released,
    .ring_index);
  tdr_checker i_tdr_checker(.ref_clk, .rst_n, .req(mif.req), .we(mif.we), .addr(mif.addr),
    .wdata(mif.wdata), .ack(mif.ack), .rdata(mif.rdata));
  always #5 ref_clk = ~ref_clk;
  // --------
  // Shared tasks
  // --------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Request held until pready is seen at an edge; data taken at that edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // --------
  // Result watcher and hang limit
  // --------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    bv_q <= buf_valid;
    if (desc_released === 1'b1) rels <= rels + 1;
    if (buf_valid === 1'b1 && bv_q !== 1'b1) begin
      seen_f = {2'b0, tx_buffer_address, buffer_octet_count, first_buffer_flag,
        last_buffer_flag, single_buffer, unit_length_valid, priority_indication, unit_length};
      check(seen_f, {2'b0, expq[0]});
      void'(expq.pop_front());
    end
    if (cyc > 6000) begin
      miscompares++;
      $display("[ERR] %0t timeout waiting on the ring", $time);
      close_out;
    end
  end
  // --------
  // Main sequence
  // --------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b1, REG_WIN, 32'h00000A5C);
    apb(1'b0, REG_WIN, 32'h0);
    check(rd, 32'h00000A5C);
    apb(1'b0, 8'h0C, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b0, REG_REL, 32'h0);
    check(rd, 32'h0);
    $display("test registers done");
    // The array is not cleared by reset, so zeros are written to make every entry start host owned
    apb(1'b1, REG_WIN, 32'h00000100);
    repeat (16) apb(1'b1, REG_DATA, 32'h0);
    run <= 1'b1;
    for (i = 0; i < 4; i++) begin
      fst = (i == 0 || i == 3);
      lst = (i >= 2);
      japan_mode_enable <= i[0];
      length_source_select <= i[1];
      cnt = 16'h0001 + (16'($random(seed)) & 16'h007F);
      w[1] = 16'($random(seed)) & 16'hFFFE;
      w[2] = 16'h0001 + (16'($random(seed)) & 16'h00FF);
      w[3] = 16'h0000 - cnt;
      w[0] = {1'b1, 1'($random(seed)), fst, lst, i[0] ? 2'($random(seed)) : 2'b00, 2'b00,
        8'($random(seed))};
      w0s[i] = w[0];
      expq.push_back({w[0][7:0], w[1][15:1], 1'b0, cnt, fst, lst, fst & lst,
        fst & !i[1], i[0] ? w[0][11:10] : 2'b00, (fst & !i[1]) ? w[2] : 16'h0});
      tx_done <= 1'b1;
      @(posedge ref_clk);
      tx_done <= 1'b0;
      // Buffer words first, ownership last
      apb(1'b1, REG_WIN, 32'h00000102 + i * 8);
      for (k = 1; k < 4; k++) apb(1'b1, REG_DATA, {16'h0, w[k]});
      apb(1'b1, REG_WIN, 32'h00000100 + i * 8);
      apb(1'b1, REG_DATA, {16'h0, w[0]});
      do @(posedge ref_clk); while (buf_valid !== 1'b1);
      repeat (1 + ($random(seed) & 3)) @(posedge ref_clk);
      tx_done <= 1'b1;
      @(posedge ref_clk);
      tx_done <= 1'b0;
      do @(posedge ref_clk); while (desc_released !== 1'b1);
      @(posedge ref_clk);
      check(ring_index, (i + 1) % 4);
      check({buf_valid, unit_length_valid, unit_length}, 18'h00000);
    end
    repeat (20) @(posedge ref_clk);
    check({ring_index, buf_valid, expq.size()}, {8'h00, 1'b0, 32'h0});
    for (i = 0; i < 4; i++) begin
      apb(1'b1, REG_WIN, 32'h00000100 + i * 8);
      apb(1'b0, REG_DATA, 32'h0);
      check(rd, {17'h0, w0s[i][14:0]});
    end
    apb(1'b0, REG_REL, 32'h0);
    check({rd, 32'(rels)}, {32'h4, 32'h4});
    // Dropping run while polling a host entry must stop the walk
    run <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check(mif.req, 1'b0);
    $display("test ring done");
    close_out;
  end
endmodule
